// *** rtl/burst_sram_pkg.sv ***
package burst_sram_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int CMD_ADDR_W = 20;
    localparam int LANE_W     = 9;
    localparam int BURST_LEN  = 4;

    // ------------------------------------------------------------
    // Beat timing, counted in ref_clk edges (one edge per clock rise)
    // ------------------------------------------------------------
    localparam logic [1:0] FIRST_BEAT = 2'h0;
    localparam logic [1:0] LAST_BEAT  = 2'h3;
    localparam logic [2:0] WAIT_IDLE  = 3'h0;
    localparam logic [2:0] WAIT_FIRE  = 3'h1;
    localparam logic [2:0] WR_LEAD    = 3'h1;
    localparam logic [2:0] RD_LEAD    = 3'h4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } last_op_type;

    localparam last_op_type LAST_OP_RESET = ST_IDLE;

    typedef struct packed
    {
        logic                  read_port_select_n;
        logic                  write_port_select_n;
        logic [CMD_ADDR_W-1:0] addr;
    } cmd_type;

endpackage

// *** rtl/lane_merge.sv ***
`timescale 1ns/1ps

module lane_merge
#(
    parameter int DATA_W = 36,
    parameter int LANE_W = 9
)
(
    input  wire logic [DATA_W-1:0]        old_word,
    input  wire logic [DATA_W-1:0]        new_word,
    input  wire logic [DATA_W/LANE_W-1:0] lane_write_n,
    output logic      [DATA_W-1:0]        merged_word
);

    // ------------------------------------------------------------
    // One 9-bit lane per select bit; a high select keeps the old lane
    // ------------------------------------------------------------
    genvar lane;
    generate
        for (lane = 0; lane < DATA_W / LANE_W; lane = lane + 1)
        begin : g_lane
            assign merged_word[lane*LANE_W +: LANE_W] =
                lane_write_n[lane] ? old_word[lane*LANE_W +: LANE_W]
                                   : new_word[lane*LANE_W +: LANE_W];
        end
    endgenerate

endmodule

// *** rtl/burst_sram_core.sv ***
// Behaviour
// [R1] Write select low at K rise starts write
// [R2] Write beats captured t+1 K through t+2 K#
// [R3] Read select low at K rise starts read
// [R4] Read beats driven t+2 K# through t+4 K
// [R5] Burst addresses run A, A+1, A+2, A+3
// [R6] Data moves on both K and K# rises
// [R7] After reset both ports idle, outputs released
// [R8] Controller deselects one K rise between starts
// [R9] Same-type request on next K rise ignored
// [R10] Select used last start is don't-care now
// [R11] Controller parks clocks high when stopped
// [R12] Narrow width: two lane selects gate beat
// [R13] Narrow width: both selects high write nothing
// [R14] Wide width: four lane selects gate beat
// [R15] Wide width: all low full, all high none
// [R16] Lane selects sampled separately every beat
// [R17] Both selects high: nothing new starts
// [R18] Without clock edges all state holds
// [R19] Both selected: read from idle, else alternate
`timescale 1ns/1ps

module burst_sram_core
import burst_sram_pkg::*;
#(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 6
)
(
    input  wire logic                     ref_clk,
    input  wire logic                     reset,
    input  wire logic                     k_rise,
    input  wire cmd_type                  cmd,
    input  wire logic [DATA_W-1:0]        write_data,
    input  wire logic [DATA_W/LANE_W-1:0] byte_write_select_n,
    output logic      [DATA_W-1:0]        read_data,
    output logic                          read_data_oe
);

    localparam int LANES = DATA_W / LANE_W;
    localparam int DEPTH = BURST_LEN << ADDR_W;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    last_op_type              last_op_reg;
    last_op_type              last_op_next;
    logic                     read_ok;
    logic                     write_ok;
    logic                     start_read;
    logic                     start_write;

    logic [ADDR_W-1:0]        wr_start_addr_reg;
    logic [2:0]               wr_wait_reg;
    logic                     wr_active_reg;
    logic [ADDR_W-1:0]        wr_addr_reg;
    logic [1:0]               wr_idx_reg;

    logic [ADDR_W-1:0]        rd_start_addr_reg;
    logic [2:0]               rd_wait_reg;
    logic                     rd_active_reg;
    logic [ADDR_W-1:0]        rd_addr_reg;
    logic [1:0]               rd_idx_reg;

    logic [DATA_W-1:0]        read_data_reg;
    logic                     read_data_oe_reg;

    logic [DATA_W-1:0]        mem_reg [0:DEPTH-1];
    logic [ADDR_W+1:0]        wr_word;
    logic [ADDR_W+1:0]        rd_word;
    logic [DATA_W-1:0]        merged_word;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Selects only count on K rises; a select that started the
    // previous operation is ignored for its own type.
    always_comb
    begin
        read_ok  = !cmd.read_port_select_n
                   && (last_op_reg != ST_READ);   // see [R3] see [R9]
        write_ok = !cmd.write_port_select_n
                   && (last_op_reg != ST_WRITE);  // see [R1] see [R10]
    end

    // When both are eligible the last operation was neither, so the
    // read wins; after a read the read is blocked and the write goes.
    always_comb
    begin
        start_read  = k_rise && read_ok;               // see [R19]
        start_write = k_rise && write_ok && !read_ok;  // see [R19]
    end

    always_comb
    begin
        last_op_next = last_op_reg;
        if (k_rise)
        begin
            if (start_read)
            begin
                last_op_next = ST_READ;
            end
            else if (start_write)
            begin
                last_op_next = ST_WRITE;
            end
            else
            begin
                last_op_next = ST_IDLE;                // see [R17]
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            last_op_reg <= LAST_OP_RESET;              // see [R7]
        end
        else
        begin
            case (last_op_next)
                ST_IDLE:  last_op_reg <= ST_IDLE;
                ST_READ:  last_op_reg <= ST_READ;
                ST_WRITE: last_op_reg <= ST_WRITE;
                default:  last_op_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write burst sequencing
    // ------------------------------------------------------------
    // The address is latched at start; beats begin two edges later so
    // a write started every other K rise overlaps its predecessor's
    // tail without needing a second burst slot.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wr_wait_reg       <= WAIT_IDLE;
            wr_start_addr_reg <= '0;
        end
        else if (start_write)
        begin
            wr_wait_reg       <= WR_LEAD;              // see [R1]
            wr_start_addr_reg <= cmd.addr[ADDR_W-1:0]; // see [R1]
        end
        else if (wr_wait_reg != WAIT_IDLE)
        begin
            wr_wait_reg <= wr_wait_reg - 3'h1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wr_active_reg <= 1'b0;                     // see [R7]
            wr_addr_reg   <= '0;
            wr_idx_reg    <= FIRST_BEAT;
        end
        else if (wr_wait_reg == WAIT_FIRE)
        begin
            wr_active_reg <= 1'b1;                     // see [R2]
            wr_addr_reg   <= wr_start_addr_reg;
            wr_idx_reg    <= FIRST_BEAT;
        end
        else if (wr_active_reg)
        begin
            wr_idx_reg <= wr_idx_reg + 2'h1;           // see [R5] see [R6]
            if (wr_idx_reg == LAST_BEAT)
            begin
                wr_active_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read burst sequencing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rd_wait_reg       <= WAIT_IDLE;
            rd_start_addr_reg <= '0;
        end
        else if (start_read)
        begin
            rd_wait_reg       <= RD_LEAD;              // see [R3] see [R4]
            rd_start_addr_reg <= cmd.addr[ADDR_W-1:0]; // see [R3]
        end
        else if (rd_wait_reg != WAIT_IDLE)
        begin
            rd_wait_reg <= rd_wait_reg - 3'h1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rd_active_reg <= 1'b0;                     // see [R7]
            rd_addr_reg   <= '0;
            rd_idx_reg    <= FIRST_BEAT;
        end
        else if (rd_wait_reg == WAIT_FIRE)
        begin
            rd_active_reg <= 1'b1;                     // see [R4]
            rd_addr_reg   <= rd_start_addr_reg;
            rd_idx_reg    <= FIRST_BEAT;
        end
        else if (rd_active_reg)
        begin
            rd_idx_reg <= rd_idx_reg + 2'h1;           // see [R5] see [R6]
            if (rd_idx_reg == LAST_BEAT)
            begin
                rd_active_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Storage and lane masking
    // ------------------------------------------------------------
    always_comb
    begin
        wr_word = {wr_addr_reg, wr_idx_reg};           // see [R5]
        rd_word = {rd_addr_reg, rd_idx_reg};           // see [R5]
    end

    // Lane selects are taken from the same edge as the data beat, so
    // each beat of one burst may carry its own mask.
    lane_merge
    #(
        .DATA_W (DATA_W),
        .LANE_W (LANE_W)
    )
    u_lane_merge
    (
        .old_word     (mem_reg[wr_word]),
        .new_word     (write_data),
        .lane_write_n (byte_write_select_n),           // see [R16]
        .merged_word  (merged_word)                    // see [R12] see [R14]
    );

    // All-high selects skip the array write: nothing changes.
    always_ff @(posedge ref_clk)
    begin
        if (wr_active_reg && (byte_write_select_n != {LANES{1'b1}}))
        begin
            mem_reg[wr_word] <= merged_word;           // see [R13] see [R15]
        end
    end

    // ------------------------------------------------------------
    // Read data drive
    // ------------------------------------------------------------
    // A read of a word being written on the same edge returns the
    // stored value; forwarding was traded away for a simpler array.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            read_data_reg    <= '0;
            read_data_oe_reg <= 1'b0;                  // see [R7]
        end
        else if (rd_active_reg)
        begin
            read_data_reg    <= mem_reg[rd_word];      // see [R4] see [R6]
            read_data_oe_reg <= 1'b1;
        end
        else
        begin
            read_data_oe_reg <= 1'b0;                  // see [R17]
        end
    end

    // With no clock edges nothing above moves, so a stopped clock
    // simply freezes the bursts and the outputs in place.
    assign read_data    = read_data_reg;               // see [R18]
    assign read_data_oe = read_data_oe_reg;

endmodule

// *** test/burst_sram_core_sva.sv ***
`timescale 1ns/1ps
module burst_sram_core_sva
import burst_sram_pkg::*;
#(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 6
)
(
    input wire logic                     ref_clk,
    input wire logic                     reset,
    input wire logic                     k_rise,
    input wire cmd_type                  cmd,
    input wire logic [DATA_W-1:0]        write_data,
    input wire logic [DATA_W/LANE_W-1:0] byte_write_select_n,
    input wire logic [DATA_W-1:0]        read_data,
    input wire logic                     read_data_oe
);
    // ------------------------------------------------
    // Accepted starts, as the arbitration should see them
    // ------------------------------------------------
    logic prev_rd_reg;
    logic prev_wr_reg;
    logic rd_go;
    logic wr_go;
    assign rd_go = k_rise && !cmd.read_port_select_n && !prev_rd_reg;
    assign wr_go = k_rise && !cmd.write_port_select_n && !prev_wr_reg
                   && !rd_go;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            prev_rd_reg <= 1'b0;
            prev_wr_reg <= 1'b0;
        end
        else if (k_rise)
        begin
            prev_rd_reg <= rd_go;
            prev_wr_reg <= wr_go;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_read_oe_window: assert property (
        rd_go |-> ##6 read_data_oe[*4]) else $error("read beats late");
    a_oe_rise_cause: assert property (
        $rose(read_data_oe) |-> $past(rd_go, 6)) else $error("oe cause");
    a_oe_burst_len: assert property (
        $rose(read_data_oe) |-> read_data_oe[*4]) else $error("burst short");
    a_oe_fall_time: assert property (
        $fell(read_data_oe) |-> $past(rd_go, 10)) else $error("oe fall");
    a_oe_source: assert property (
        read_data_oe |-> $past(rd_go, 6) || $past(rd_go, 7)
        || $past(rd_go, 8) || $past(rd_go, 9)) else $error("stray oe");
    a_read_repeat_drop: assert property (
        (rd_go ##2 (k_rise && !cmd.read_port_select_n) ##2 !rd_go)
        |-> ##6 !read_data_oe) else $error("second read taken");
    a_reset_idle_out: assert property (disable iff (1'b0)
        reset |=> !read_data_oe && read_data == '0) else $error("reset");
    a_data_hold_off: assert property (
        !$past(reset) && $changed(read_data) |-> read_data_oe)
        else $error("data moved while off");
    c_read: cover property (rd_go);
    c_write: cover property (wr_go);
    c_both_low: cover property (rd_go && !cmd.write_port_select_n);
    c_repeat: cover property (rd_go ##2 (k_rise && !cmd.read_port_select_n));
endmodule

bind burst_sram_core burst_sram_core_sva #(.DATA_W(DATA_W), .ADDR_W(ADDR_W))
    i_burst_sram_core_sva (.ref_clk(ref_clk), .reset(reset),
    .k_rise(k_rise), .cmd(cmd), .write_data(write_data),
    .byte_write_select_n(byte_write_select_n), .read_data(read_data),
    .read_data_oe(read_data_oe));

// *** test/sram_ctrl_model.sv ***
`timescale 1ns/1ps
module sram_ctrl_model
import burst_sram_pkg::*;
#(
    parameter int DATA_W = 36
)
(
    input  wire logic                ref_clk,
    output logic                     k_rise,
    output cmd_type                  cmd,
    output logic [DATA_W-1:0]        write_data,
    output logic [DATA_W/LANE_W-1:0] byte_write_select_n
);
    // ------------------------------------------------
    // Controller side: all changes land on falling edges
    // ------------------------------------------------
    initial
    begin
        k_rise = 1'b0;
        cmd = '{1'b1, 1'b1, '0};
        write_data = '0;
        byte_write_select_n = '1;
    end
    always @(negedge ref_clk)
        k_rise <= ~k_rise;
    // Old k_rise low here means the coming edge is a positive rise
    task automatic send(input logic rd_n, input logic wr_n,
                        input logic [CMD_ADDR_W-1:0] a);
        @(negedge ref_clk);
        while (k_rise)
            @(negedge ref_clk);
        cmd = '{rd_n, wr_n, a};
    endtask
    task automatic write(input logic [CMD_ADDR_W-1:0] a,
                         input logic [3:0][DATA_W-1:0] d,
                         input logic [3:0][DATA_W/LANE_W-1:0] m);
        send(1'b1, 1'b0, a);
        @(negedge ref_clk);
        cmd.write_port_select_n = 1'b1;
        for (int j = 0; j < 4; j++)
        begin
            @(negedge ref_clk);
            write_data = d[j];
            byte_write_select_n = m[j];
        end
        // Released lines never keep the last value
        @(negedge ref_clk);
        write_data = ~write_data;
        byte_write_select_n = ~byte_write_select_n;
    endtask
endmodule

// *** test/burst_sram_core_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module burst_sram_core_tb;
import burst_sram_pkg::*;
    localparam int DATA_W = 36;
    logic              ref_clk = 1'b0;
    logic              reset;
    logic              k_rise;
    cmd_type           cmd;
    logic [DATA_W-1:0] write_data;
    logic [3:0]        byte_write_select_n;
    logic [DATA_W-1:0] read_data;
    logic              read_data_oe;
    logic [DATA_W-1:0] mem [256];
    int                fails = 0;
    int                checked = 0;
    int                cycles = 0;
    logic              clk_run = 1'b1;
    // A stopped clock parks high so that restart is clean
    always #2 ref_clk = clk_run ? ~ref_clk : 1'b1;
    burst_sram_core #(.DATA_W(DATA_W), .ADDR_W(6)) i_burst_sram_core (
        .ref_clk(ref_clk), .reset(reset), .k_rise(k_rise), .cmd(cmd),
        .write_data(write_data), .byte_write_select_n(byte_write_select_n),
        .read_data(read_data), .read_data_oe(read_data_oe));
    sram_ctrl_model #(.DATA_W(DATA_W)) i_sram_ctrl_model (
        .ref_clk(ref_clk), .k_rise(k_rise), .cmd(cmd),
        .write_data(write_data), .byte_write_select_n(byte_write_select_n));
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic tb_merge(input logic [5:0] a, input logic [3:0][35:0] d,
                            input logic [3:0][3:0] m);
        for (int j = 0; j < 4; j++)
            for (int l = 0; l < 4; l++)
                if (!m[j][l])
                    mem[{a, 2'(j)}][l*LANE_W +: LANE_W] =
                        d[j][l*LANE_W +: LANE_W];
    endtask
    task automatic tb_write(input logic [5:0] a, input logic [3:0][35:0] d,
                            input logic [3:0][3:0] m);
        tb_merge(a, d, m);
        i_sram_ctrl_model.write({14'h0, a}, d, m);
    endtask
    // Second command one positive rise later: idle, repeat or both-low
    task automatic tb_read(input logic [5:0] a, input logic w1_n,
                           input logic r2_n, input logic w2_n,
                           input logic stall = 1'b0);
        i_sram_ctrl_model.send(1'b0, w1_n, {14'h0, a});
        i_sram_ctrl_model.send(r2_n, w2_n, {14'h0, a ^ 6'h01});
        i_sram_ctrl_model.send(1'b1, 1'b1, '0);
        repeat (2) @(negedge ref_clk);
        for (int j = 0; j < 4; j++)
        begin
            `CHK("oe", 1'b1, read_data_oe)
            `CHK("data", mem[{a, 2'(j)}], read_data)
            if (stall && j == 0)
            begin
                // Off the half-period grid so the restart edge is seen
                clk_run = 1'b0;
                #39;
                `CHK("stall oe", 1'b1, read_data_oe)
                `CHK("stall data", mem[{a, 2'h1}], read_data)
                clk_run = 1'b1;
            end
            @(negedge ref_clk);
        end
        `CHK("oe off", 1'b0, read_data_oe)
    endtask
    task automatic complete_run;
        $display("Checked %0d, errors %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            complete_run();
        end
    end
    initial
    begin
        reset = 1'b1;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        `CHK("oe reset", 1'b0, read_data_oe)
        `CHK("data reset", 36'h0, read_data)
        tb_write(6'h05, {36'h123456789, 36'h9abcdef01, 36'h2468ace13,
                 36'h13579bdf0}, 16'h0);
        tb_read(6'h05, 1'b1, 1'b1, 1'b1, 1'b1);
        tb_write(6'h05, {4{36'hfffffffff}}, 16'hf7be);
        tb_read(6'h05, 1'b1, 1'b1, 1'b1);
        tb_read(6'h05, 1'b1, 1'b0, 1'b1);
        tb_merge(6'h04, {4{write_data}},
                 {4{byte_write_select_n}});
        tb_read(6'h05, 1'b0, 1'b0, 1'b0);
        tb_read(6'h04, 1'b1, 1'b1, 1'b1);
        complete_run();
    end
endmodule
